// *** core/eag_pkg.sv ***
// Shared types and constants for the effective address generator.
// Assumes the decoder and bus logic of the CPU share the same clock.
package eag_pkg;

	typedef enum logic [3:0] {
		EAG_REG_INDIRECT,
		EAG_REG_DISP16,
		EAG_REG_DISP32,
		EAG_POST_INC,
		EAG_PRE_DEC,
		EAG_ABS8,
		EAG_ABS16,
		EAG_ABS24,
		EAG_ABS32,
		EAG_PC_REL8,
		EAG_PC_REL16,
		EAG_MEM_INDIRECT,
		EAG_TRAP
	} eag_mode_t;

	typedef enum logic [1:0] {
		EAG_SIZE_BYTE,
		EAG_SIZE_WORD,
		EAG_SIZE_LONG
	} eag_size_t;

	// Request from the instruction decoder.
	typedef struct packed {
		logic      valid;
		eag_mode_t mode;
		eag_size_t size;
		logic [2:0]  reg_sel;
		logic [31:0] reg_value;
		logic [31:0] ext;
		logic [23:0] pc_next;
		logic [1:0]  trap_imm;
	} eag_req_t;

	// Answer towards the bus and register-file logic.
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        wb_en;
		logic [2:0]  wb_reg;
		logic [31:0] wb_value;
		logic        indirect;
	} eag_ans_t;

	localparam logic [31:0] EAG_STEP_BYTE   = 32'h0000_0001;
	localparam logic [31:0] EAG_STEP_WORD   = 32'h0000_0002;
	localparam logic [31:0] EAG_STEP_LONG   = 32'h0000_0004;
	localparam logic [23:0] EAG_SHORT_UPPER = 24'hFFFFFF;
	localparam logic [7:0]  EAG_PROG_UPPER  = 8'h00;
	localparam logic [31:0] EAG_TRAP_BASE   = 32'h0000_0020;
	localparam int          EAG_TRAP_SHIFT  = 2;
	localparam int          EAG_NORMAL_BITS = 16;

endpackage : eag_pkg

// *** core/eag_size_step.sv ***
// Operand size to auto-modify step lookup.
// Purely combinational; used by the address generator top.
`timescale 1ns/1ps
module eag_size_step (
	input  eag_pkg::eag_size_t size,
	output logic [31:0]        step
);
	import eag_pkg::*;

	always_comb
	begin
		unique case (size)
			EAG_SIZE_BYTE: step = EAG_STEP_BYTE;
			EAG_SIZE_WORD: step = EAG_STEP_WORD;
			EAG_SIZE_LONG: step = EAG_STEP_LONG;
			default:       step = EAG_STEP_BYTE;
		endcase
	end

endmodule : eag_size_step

// *** core/eag_top.sv ***
// Effective address generator: forms operand and branch addresses for the CPU.
// Assumes decoder inputs are synchronous to sys_clk and the far side keeps
// address registers and branch targets even where required.
// Notes on behaviour
// RL1 - Pre-decrement subtracts 1, 2 or 4, uses and writes back result.
// RL2 - Software keeps address registers even for word/long auto-modify use.
// RL3 - Short absolute data address has upper 24 bits forced to one.
// RL4 - Sixteen-bit absolute address is sign-extended from bit 15.
// RL5 - Thirty-two-bit absolute address passes through unchanged.
// RL6 - Program absolute address has upper eight bits zeroed.
// RL7 - PC relative sign-extends 8/16-bit displacement, adds to 24-bit PC.
// RL8 - PC relative target keeps low 24 bits, upper eight zero.
// RL9 - PC base is the address of the byte after the branch.
// RL10 - Software picks displacements giving even branch targets.
// RL11 - PC relative serves conditional branch and branch to subroutine.
// RL12 - Memory indirect zero-extends 8-bit field, table at 0 to 255.
// RL13 - Normal mode fetches a word, used as 16-bit branch address.
// RL14 - Advanced mode fetches a longword, top byte treated as zero.
// RL15 - Normal mode drops upper sixteen address bits, drives 16 bits.
// RL16 - Trap instruction 2-bit immediate selects the vector address.
// RL17 - Post-increment uses register, then adds 1, 2 or 4 back.
// RL18 - Register displacement adds; 16-bit displacement sign-extended first.
// RL19 - Address and write-back appear together, one cycle after request.
`timescale 1ns/1ps
module eag_top (
	input  logic              sys_clk,
	input  logic              rst_n,
	input  logic              advanced_mode,
	input  eag_pkg::eag_req_t req,
	input  logic              table_valid,
	input  logic [31:0]       table_data,
	output eag_pkg::eag_ans_t ans,
	output logic              target_valid,
	output logic [31:0]       target_addr
);
	import eag_pkg::*;

	logic [31:0] step;
	logic [31:0] ea_full;
	logic [31:0] ea_masked;
	logic [31:0] wb_calc;
	logic        wb_calc_en;
	logic [31:0] pc_sum;
	logic [31:0] disp_ext;
	logic [31:0] fetched;
	eag_ans_t    ans_reg;
	eag_ans_t    ans_next;
	logic        target_valid_reg;
	logic [31:0] target_addr_reg;

	eag_size_step u_step (
		.size (req.size),
		.step (step)
	);

	// The PC base is already the address following the branch instruction.
	always_comb
	begin
		disp_ext = (req.mode == EAG_PC_REL8) ? {{24{req.ext[7]}}, req.ext[7:0]}
			: {{16{req.ext[15]}}, req.ext[15:0]}; // RL7
		pc_sum   = {EAG_PROG_UPPER, 24'(32'({8'h00, req.pc_next}) + disp_ext)}; // RL7 RL8 RL9
	end

	always_comb
	begin
		ea_full    = req.reg_value;
		wb_calc    = req.reg_value;
		wb_calc_en = 1'b0;
		unique case (req.mode)
			EAG_REG_INDIRECT: ea_full = req.reg_value;
			EAG_REG_DISP16:   ea_full = req.reg_value + {{16{req.ext[15]}}, req.ext[15:0]}; // RL18
			EAG_REG_DISP32:   ea_full = req.reg_value + req.ext; // RL18
			EAG_POST_INC:
			begin
				ea_full    = req.reg_value; // RL17
				wb_calc    = req.reg_value + step; // RL17
				wb_calc_en = 1'b1;
			end
			EAG_PRE_DEC:
			begin
				ea_full    = req.reg_value - step; // RL1
				wb_calc    = req.reg_value - step; // RL1
				wb_calc_en = 1'b1;
			end
			EAG_ABS8:         ea_full = {EAG_SHORT_UPPER, req.ext[7:0]}; // RL3
			EAG_ABS16:        ea_full = {{16{req.ext[15]}}, req.ext[15:0]}; // RL4
			EAG_ABS24:        ea_full = {EAG_PROG_UPPER, req.ext[23:0]}; // RL6
			EAG_ABS32:        ea_full = req.ext; // RL5
			EAG_PC_REL8,
			EAG_PC_REL16:     ea_full = pc_sum; // RL11
			EAG_MEM_INDIRECT: ea_full = {24'h000000, req.ext[7:0]}; // RL12
			EAG_TRAP:         ea_full = EAG_TRAP_BASE
				+ 32'({30'h0, req.trap_imm} << EAG_TRAP_SHIFT); // RL16
			default:          ea_full = req.reg_value;
		endcase
	end

	// Normal mode keeps only the low 16 bits of every address.
	assign ea_masked = advanced_mode ? ea_full
		: {16'h0000, ea_full[EAG_NORMAL_BITS-1:0]}; // RL15

	always_comb
	begin
		ans_next          = '0;
		ans_next.valid    = req.valid;
		ans_next.addr     = ea_masked;
		ans_next.wb_en    = req.valid & wb_calc_en;
		ans_next.wb_reg   = req.reg_sel;
		ans_next.wb_value = wb_calc;
		ans_next.indirect = req.valid & (req.mode == EAG_MEM_INDIRECT);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			ans_reg <= '0;
		else
			ans_reg <= ans_next; // RL19
	end

	// The table entry returned by the bus becomes the branch address.
	always_comb
	begin
		if (advanced_mode)
			fetched = {EAG_PROG_UPPER, table_data[23:0]}; // RL14
		else
			fetched = {16'h0000, table_data[15:0]}; // RL13
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			target_valid_reg <= 1'b0;
			target_addr_reg  <= 32'h0000_0000;
		end
		else
		begin
			target_valid_reg <= table_valid;
			if (table_valid)
				target_addr_reg <= fetched;
		end
	end

	assign ans          = ans_reg;
	assign target_valid = target_valid_reg;
	assign target_addr  = target_addr_reg;

	abs_short_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL3
		(req.valid && req.mode == EAG_ABS8 && advanced_mode)
		|=> (ans.addr[31:8] == 24'hFFFFFF && ans.addr[7:0] == $past(req.ext[7:0])))
		else $error("short absolute upper bits wrong");

	abs_normal_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL3
		(req.valid && req.mode == EAG_ABS8 && !advanced_mode)
		|=> (ans.addr == {16'h0000, 8'hFF, $past(req.ext[7:0])}))
		else $error("short absolute normal address wrong");

	abs_sign_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL4
		(req.valid && req.mode == EAG_ABS16 && advanced_mode)
		|=> (ans.addr[31:16] == {16{ans.addr[15]}} && ans.addr[15:0] == $past(req.ext[15:0])))
		else $error("absolute sign extension wrong");

	abs_full_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
		(req.valid && req.mode == EAG_ABS32 && advanced_mode)
		|=> (ans.addr == $past(req.ext)))
		else $error("long absolute not passed through");

	prog_abs_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
		(req.valid && req.mode == EAG_ABS24)
		|=> (ans.addr[31:24] == 8'h00))
		else $error("program address upper byte not zero");

	prog_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
		(req.valid && req.mode == EAG_ABS24 && advanced_mode)
		|=> (ans.addr[23:0] == $past(req.ext[23:0])))
		else $error("program address low bits wrong");

	pc_short_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL7
		(req.valid && req.mode == EAG_PC_REL8 && advanced_mode)
		|=> (ans.addr[23:0] == 24'($past(req.pc_next) + {{16{$past(req.ext[7])}},
			$past(req.ext[7:0])})))
		else $error("short pc relative target wrong");

	pc_long_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL7
		(req.valid && req.mode == EAG_PC_REL16 && advanced_mode)
		|=> (ans.addr[23:0] == 24'($past(req.pc_next) + {{8{$past(req.ext[15])}},
			$past(req.ext[15:0])})))
		else $error("long pc relative target wrong");

	pc_normal_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL15
		(req.valid && req.mode == EAG_PC_REL8 && !advanced_mode)
		|=> (ans.addr[15:0] == 16'($past(req.pc_next[15:0]) + {{8{$past(req.ext[7])}},
			$past(req.ext[7:0])})))
		else $error("normal pc relative target wrong");

	pc_upper_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL8
		(req.valid && (req.mode == EAG_PC_REL8 || req.mode == EAG_PC_REL16))
		|=> (ans.addr[31:24] == 8'h00))
		else $error("pc relative upper byte not zero");

	pre_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
		(req.valid && req.mode == EAG_PRE_DEC && req.size == EAG_SIZE_LONG && advanced_mode)
		|=> (ans.wb_en && ans.addr == ans.wb_value
			&& ans.wb_value == $past(req.reg_value) - 32'h4))
		else $error("pre-decrement result wrong");

	pre_dec_byte_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
		(req.valid && req.mode == EAG_PRE_DEC && req.size == EAG_SIZE_BYTE && advanced_mode)
		|=> (ans.wb_en && ans.addr == ans.wb_value
			&& ans.wb_value == $past(req.reg_value) - 32'h1))
		else $error("byte pre-decrement result wrong");

	pre_dec_word_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
		(req.valid && req.mode == EAG_PRE_DEC && req.size == EAG_SIZE_WORD && advanced_mode)
		|=> (ans.wb_en && ans.addr == ans.wb_value
			&& ans.wb_value == $past(req.reg_value) - 32'h2))
		else $error("word pre-decrement result wrong");

	post_inc_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL17
		(req.valid && req.mode == EAG_POST_INC && req.size == EAG_SIZE_WORD && advanced_mode)
		|=> (ans.wb_en && ans.wb_value == ans.addr + 32'h2))
		else $error("post-increment result wrong");

	post_inc_byte_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL17
		(req.valid && req.mode == EAG_POST_INC && req.size == EAG_SIZE_BYTE && advanced_mode)
		|=> (ans.wb_en && ans.addr == $past(req.reg_value)
			&& ans.wb_value == $past(req.reg_value) + 32'h1))
		else $error("byte post-increment result wrong");

	post_inc_long_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL17
		(req.valid && req.mode == EAG_POST_INC && req.size == EAG_SIZE_LONG && advanced_mode)
		|=> (ans.wb_en && ans.addr == $past(req.reg_value)
			&& ans.wb_value == $past(req.reg_value) + 32'h4))
		else $error("long post-increment result wrong");

	wb_target_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
		(req.valid && (req.mode == EAG_PRE_DEC || req.mode == EAG_POST_INC))
		|=> (ans.wb_en && ans.wb_reg == $past(req.reg_sel)))
		else $error("write-back register wrong");

	wb_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL19
		(req.valid && req.mode != EAG_PRE_DEC && req.mode != EAG_POST_INC)
		|=> (ans.valid && !ans.wb_en))
		else $error("write-back without auto-modify");

	reg_disp_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL18
		(req.valid && req.mode == EAG_REG_DISP16 && advanced_mode)
		|=> (ans.addr == $past(req.reg_value) + {{16{$past(req.ext[15])}},
			$past(req.ext[15:0])}))
		else $error("short displacement address wrong");

	reg_disp_long_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL18
		(req.valid && req.mode == EAG_REG_DISP32 && advanced_mode)
		|=> (ans.addr == $past(req.reg_value) + $past(req.ext)))
		else $error("long displacement address wrong");

	mem_table_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL12
		(req.valid && req.mode == EAG_MEM_INDIRECT)
		|=> (ans.indirect && ans.addr[31:8] == 24'h000000))
		else $error("table pointer out of range");

	mem_ptr_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL12
		(req.valid && req.mode == EAG_MEM_INDIRECT)
		|=> (ans.addr[7:0] == $past(req.ext[7:0])))
		else $error("table pointer value wrong");

	indirect_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL12
		(req.valid && req.mode != EAG_MEM_INDIRECT) |=> (!ans.indirect))
		else $error("indirect flag without table mode");

	trap_vector_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL16
		(req.valid && req.mode == EAG_TRAP && advanced_mode)
		|=> (ans.addr == EAG_TRAP_BASE + (32'($past(req.trap_imm)) << EAG_TRAP_SHIFT)))
		else $error("trap vector address wrong");

	normal_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL15
		(req.valid && !advanced_mode) |=> (ans.addr[31:16] == 16'h0000))
		else $error("normal mode upper bits not dropped");

	fetch_long_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL14
		(table_valid && advanced_mode)
		|=> (target_valid && target_addr[31:24] == 8'h00))
		else $error("advanced fetched address top byte not zero");

	fetch_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL14
		(table_valid && advanced_mode)
		|=> (target_addr[23:0] == $past(table_data[23:0])))
		else $error("advanced fetched address wrong");

	fetch_word_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL13
		(table_valid && !advanced_mode)
		|=> (target_valid && target_addr == {16'h0000, $past(table_data[15:0])}))
		else $error("normal fetched address wrong");

	target_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL13
		(!table_valid) |=> (!target_valid && $stable(target_addr)))
		else $error("branch address changed without fetch");

	ans_valid_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL19
		(req.valid) |=> (ans.valid))
		else $error("request not answered");

	no_wb_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL19
		(!req.valid) |=> (!ans.valid && !ans.wb_en))
		else $error("answer without request");

endmodule : eag_top

// *** test/eag_bus_model.sv ***
// Bus side model: answers memory-indirect table fetches after a delay.
// Assumes it shares sys_clk with the generator.
`timescale 1ns/1ps
module eag_bus_model (
	input  logic              sys_clk,
	input  logic              rst_n,
	input  eag_pkg::eag_ans_t ans,
	input  logic [3:0]        delay,
	output logic              table_valid,
	output logic [31:0]       table_data
);
	import eag_pkg::*;
	logic       busy_reg;
	logic [3:0] wait_reg;
	logic [7:0] ptr_reg;
	// Outside reset and a return the data toggles so that a stale value is never mistaken for data.
	always_ff @(posedge sys_clk)
	begin
		table_valid <= 1'b0;
		table_data  <= ~table_data;
		if (!rst_n)
		begin
			busy_reg   <= 1'b0;
			table_data <= 32'hA5A5_5A5A;
		end
		else if (!busy_reg && ans.valid && ans.indirect)
		begin
			busy_reg <= 1'b1;
			wait_reg <= delay;
			ptr_reg  <= ans.addr[7:0];
		end
		else if (busy_reg && wait_reg == 4'h0)
		begin
			busy_reg    <= 1'b0;
			table_valid <= 1'b1;
			table_data  <= {~ptr_reg, ptr_reg, ptr_reg ^ 8'h5A, ptr_reg & 8'hFE};
		end
		else if (busy_reg)
			wait_reg <= wait_reg - 4'h1;
	end
endmodule : eag_bus_model

// *** test/tb_top.sv ***
// Self-checking bench for the effective address generator.
// Assumes one answer per request, one cycle later.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	import eag_pkg::*;
	logic        sys_clk, rst_n, advanced_mode, table_valid, target_valid, tv_seen;
	logic [31:0] table_data, target_addr, tgt_exp;
	logic [3:0]  delay;
	eag_req_t    req;
	eag_ans_t    ans, exp_reg;
	int          error_cnt, checks_done, seed;
	eag_top eag_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .advanced_mode(advanced_mode),
		.req(req), .table_valid(table_valid), .table_data(table_data), .ans(ans),
		.target_valid(target_valid), .target_addr(target_addr));
	eag_bus_model eag_bus_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .ans(ans),
		.delay(delay), .table_valid(table_valid), .table_data(table_data));
	function automatic eag_ans_t expect_ans(eag_req_t r, logic adv);
		eag_ans_t    a;
		logic [31:0] st;
		st = r.size == EAG_SIZE_BYTE ? EAG_STEP_BYTE
			: r.size == EAG_SIZE_WORD ? EAG_STEP_WORD : EAG_STEP_LONG;
		a = '0;
		case (r.mode)
		EAG_REG_DISP16: a.addr = r.reg_value + {{16{r.ext[15]}}, r.ext[15:0]};
		EAG_REG_DISP32: a.addr = r.reg_value + r.ext;
		EAG_PRE_DEC: a.addr = r.reg_value - st;
		EAG_ABS8: a.addr = {EAG_SHORT_UPPER, r.ext[7:0]};
		EAG_ABS16: a.addr = {{16{r.ext[15]}}, r.ext[15:0]};
		EAG_ABS24: a.addr = {8'h00, r.ext[23:0]};
		EAG_ABS32: a.addr = r.ext;
		EAG_PC_REL8: a.addr = {8'h00, r.pc_next + {{16{r.ext[7]}}, r.ext[7:0]}};
		EAG_PC_REL16: a.addr = {8'h00, r.pc_next + {{8{r.ext[15]}}, r.ext[15:0]}};
		EAG_MEM_INDIRECT: a.addr = {24'h000000, r.ext[7:0]};
		EAG_TRAP: a.addr = EAG_TRAP_BASE + {28'h0000000, r.trap_imm, 2'h0};
		default: a.addr = r.reg_value;
		endcase
		a.valid = r.valid;
		a.wb_en = r.valid && (r.mode == EAG_POST_INC || r.mode == EAG_PRE_DEC);
		a.wb_reg = r.reg_sel;
		a.wb_value = r.mode == EAG_POST_INC ? r.reg_value + st : a.addr;
		a.indirect = r.valid && r.mode == EAG_MEM_INDIRECT;
		if (!adv)
			a.addr[31:16] = 16'h0000;
		return a;
	endfunction : expect_ans
	function automatic eag_req_t mk(eag_mode_t m, eag_size_t s, logic [31:0] v, logic [31:0] e);
		mk = '{1'b1, m, s, 3'h5, v, e, e[31:8], e[1:0]};
	endfunction : mk
	function automatic eag_req_t rnd_req();
		eag_req_t r;
		r = mk(eag_mode_t'($unsigned($random(seed)) % 13), eag_size_t'($unsigned($random(seed)) % 3),
			$random(seed), $random(seed));
		r.valid = ($random(seed) & 3) != 0;
		r.reg_sel = 3'($random(seed));
		if (r.size != EAG_SIZE_BYTE)
			r.reg_value[0] = 1'b0;
		if (r.mode inside {EAG_PC_REL8, EAG_PC_REL16})
			r.ext[0] = 1'b0;
		r.pc_next[0] = 1'b0;
		return r;
	endfunction : rnd_req
	task automatic drive(eag_req_t r);
		@(negedge sys_clk);
		`CHK(ans.valid, exp_reg.valid)
		if (exp_reg.valid)
		begin
			`CHK(ans.addr, exp_reg.addr)
			`CHK({ans.wb_en, ans.indirect}, {exp_reg.wb_en, exp_reg.indirect})
			if (exp_reg.wb_en)
				`CHK({ans.wb_reg, ans.wb_value}, {exp_reg.wb_reg, exp_reg.wb_value})
		end
		req = r;
		delay = 4'($random(seed));
		exp_reg = expect_ans(r, advanced_mode);
	endtask : drive
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	always @(posedge sys_clk)
	begin
		tv_seen <= table_valid & rst_n;
		tgt_exp <= advanced_mode ? {8'h00, table_data[23:0]} : {16'h0000, table_data[15:0]};
	end
	always @(negedge sys_clk)
		if (rst_n)
		begin
			`CHK(target_valid, tv_seen)
			if (tv_seen)
				`CHK(target_addr, tgt_exp)
		end
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial
	begin
		repeat (8000) @(posedge sys_clk);
		error_cnt++;
		wrap_up();
	end
	initial
	begin
		{seed, error_cnt, checks_done} = {32'h2e1f, 64'h0};
		{rst_n, advanced_mode, delay} = 6'h00;
		{req, exp_reg} = '0;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHK(ans.valid, 1'b0)
		rst_n = 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			advanced_mode = m[0];
			drive(mk(EAG_PRE_DEC, EAG_SIZE_LONG, 32'h0000_0000, 32'h0000_0080));
			drive(mk(EAG_PRE_DEC, EAG_SIZE_BYTE, 32'h0000_0001, 32'hFFFF_FFFF));
			drive(mk(EAG_POST_INC, EAG_SIZE_LONG, 32'hFFFF_FFFC, 32'h0000_8000));
			drive(mk(EAG_PC_REL8, EAG_SIZE_WORD, 32'h0000_0002, 32'h0000_0080));
			drive(mk(EAG_PC_REL16, EAG_SIZE_WORD, 32'h0000_0002, 32'hFFFF_FE02));
			for (int i = 0; i < 13; i++)
				drive(mk(eag_mode_t'(i), EAG_SIZE_WORD, 32'h8001_2346, 32'h8000_FFFF - i));
			repeat (400) drive(rnd_req());
			repeat (20) drive('0);
			$display("test pass %0d done", m);
		end
		wrap_up();
	end
endmodule : tb_top
